/* sim/cfd_dec_monitor.sv */
// assertions tying decoded outputs to the offered compute field
`timescale 1ns/10ps
`include "cfd_defines.vh"
module cfd_dec_monitor (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // sequencer side
  input logic        seq_valid,
  input logic        seq_short,
  input logic [22:0] seq_field,
  // decoded operation
  input logic        dec_valid,
  input logic [2:0]  dec_kind,
  input logic [1:0]  dec_unit,
  input logic [1:0]  dec_fmt,
  input logic [7:0]  dec_op,
  input logic [1:0]  dec_dst,
  input logic        dec_dst_is_src
);
  logic        v_r;
  logic        s_r;
  logic [22:0] f_r;
  logic        lng;
  logic        sht;
  // last cycle's offer, the cause of this cycle's decode
  always @(posedge aclk) begin
    v_r <= seq_valid;
    s_r <= seq_short;
    f_r <= seq_field;
  end
  assign lng = dec_valid && v_r && !s_r;
  assign sht = dec_valid && v_r && s_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_shifter_one: assert property (
    lng && !f_r[22] && f_r[21:20] == `CFD_UNIT_SHF |-> dec_kind == `CFD_KIND_ONE
      && dec_unit == `CFD_UNIT_SHF && dec_op == f_r[19:12])
    else $error("shifter field decoded wrongly");
  a_mul_format: assert property (
    lng && f_r[22:20] == 3'h1 && (f_r[19:12] == 8'h30 || f_r[19:12] == 8'h33)
      |-> dec_fmt == (f_r[12] ? `CFD_FMT_F64 : `CFD_FMT_F40))
    else $error("multiplier float format wrong");
  a_accum_kind: assert property (
    lng && f_r[22:20] == 3'h1 && f_r[19:17] == 3'h0 |-> dec_kind == `CFD_KIND_ACCUM)
    else $error("accumulator transfer not recognised");
  a_addsub_pair: assert property (
    lng && f_r[22:20] == 3'h0 && f_r[18:16] == 3'h7 |-> dec_kind == `CFD_KIND_ADDSUB
      && dec_fmt == (f_r[19] ? `CFD_FMT_F40 : `CFD_FMT_FIX))
    else $error("dual add or subtract decoded wrongly");
  a_dual_format: assert property (
    lng && f_r[22:21] == 2'h2 |-> dec_kind == `CFD_KIND_DUAL && dec_op == {2'h0, f_r[21:16]}
      && dec_fmt == (f_r[20:19] == 2'h0 && f_r[17:16] == 2'h3 ? `CFD_FMT_F64 :
                     f_r[20:19] == 2'h3 ? `CFD_FMT_F40 : `CFD_FMT_FIX))
    else $error("parallel field decoded wrongly");
  a_mul_addsub: assert property (
    lng && f_r[22:21] == 2'h3 |-> dec_kind == `CFD_KIND_MULADDSUB
      && dec_fmt == (f_r[20] ? `CFD_FMT_F40 : `CFD_FMT_FIX))
    else $error("multiply with add or subtract decoded wrongly");
  a_short_form: assert property (
    sht && f_r[15:12] == `CFD_STAG_VAL |-> dec_kind == `CFD_KIND_SHORT
      && dec_dst_is_src && dec_op == {4'h0, f_r[11:8]})
    else $error("short compute decoded wrongly");
  a_short_nop: assert property (
    sht && f_r[15:12] != `CFD_STAG_VAL |-> dec_kind == `CFD_KIND_NOP
      && dec_dst == `CFD_DST_NONE && dec_op == 8'h00)
    else $error("short word without tag not a no-op");
endmodule
bind cfd_decoder cfd_dec_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .seq_valid(seq_valid), .seq_short(seq_short),
  .seq_field(seq_field), .dec_valid(dec_valid), .dec_kind(dec_kind), .dec_unit(dec_unit),
  .dec_fmt(dec_fmt), .dec_op(dec_op), .dec_dst(dec_dst), .dec_dst_is_src(dec_dst_is_src)
);

/* sim/cfd_seq_model.sv */
// sequencer model offering compute fields to the decoder
`timescale 1ns/10ps
module cfd_seq_model (
  // clock
  input  logic        aclk,
  // offered field
  output logic        seq_valid,
  output logic        seq_short,
  output logic [22:0] seq_field
);
  initial begin
    seq_valid = 1'b0;
    seq_short = 1'b0;
    seq_field = 23'h000000;
  end
  // one cycle per field, then gap idle cycles with scrambled field lines
  task automatic offer(input logic sh, input logic [22:0] f, input int gap);
    begin
      @(posedge aclk);
      seq_valid <= 1'b1;
      seq_short <= sh;
      seq_field <= sh ? {7'h00, f[15:0]} : f;
      repeat (gap) begin
        @(posedge aclk);
        seq_valid <= 1'b0;
        seq_field <= ~f;
      end
    end
  endtask
endmodule

/* sim/tb.sv */
// self-checking bench for the compute field decoder
`timescale 1ns/10ps
`include "cfd_defines.vh"
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        seq_valid, seq_short;
  logic [22:0] seq_field;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, dec_unit, dec_fmt, dec_dst;
  logic        dec_valid, dec_two_src, dec_carry, dec_dst_is_src;
  logic [2:0]  dec_kind;
  logic [7:0]  dec_op;
  logic [16:0] dq[$];
  logic [33:0] rq[$];
  logic [33:0] bq[$];
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] rnd = 32'h0000005B;
  logic [7:0]  alu_ops [53] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B, 8'h21,
    8'h22, 8'h25, 8'h26, 8'h29, 8'h2A, 8'h30, 8'h40, 8'h41, 8'h42, 8'h43, 8'h61, 8'h62,
    8'h63, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h81, 8'h82, 8'h89, 8'h8A,
    8'h91, 8'h92, 8'hA1, 8'hA2, 8'hA5, 8'hAD, 8'hB0, 8'hBD, 8'hC1, 8'hC4, 8'hC5, 8'hC9,
    8'hCA, 8'hCD, 8'hD9, 8'hDA, 8'hDD, 8'hE0, 8'hE1, 8'hE2, 8'hE3};
  always #25 aclk = ~aclk;
  cfd_seq_model seq_m (.aclk(aclk), .seq_valid(seq_valid), .seq_short(seq_short),
    .seq_field(seq_field));
  cfd_decoder dut (.aclk(aclk), .aresetn(aresetn), .seq_valid(seq_valid),
    .seq_short(seq_short), .seq_field(seq_field), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .dec_valid(dec_valid),
    .dec_kind(dec_kind), .dec_unit(dec_unit), .dec_fmt(dec_fmt), .dec_op(dec_op),
    .dec_dst(dec_dst), .dec_two_src(dec_two_src), .dec_carry(dec_carry),
    .dec_dst_is_src(dec_dst_is_src));
  function automatic logic [16:0] exp_dec(input logic sh, input logic [22:0] f);
    logic [2:0] k;
    logic [1:0] u;
    logic [1:0] fm;
    logic [7:0] op;
    logic       c;
    begin
      k = `CFD_KIND_NOP;
      u = `CFD_UNIT_ALU;
      fm = `CFD_FMT_FIX;
      op = f[19:12];
      c = 1'b0;
      if (sh) begin
        op = {4'h0, f[11:8]};
        if (f[15:12] == `CFD_STAG_VAL) k = `CFD_KIND_SHORT;
        if (f[11:10] == 2'h2 || f[11:8] == 4'hF) fm = `CFD_FMT_F40;
        if (f[11:8] == 4'h7 || f[11:8] == 4'hF) u = `CFD_UNIT_MUL;
      end else if (f[22]) begin
        op = {2'h0, f[21:16]};
        k = f[21] ? `CFD_KIND_MULADDSUB : `CFD_KIND_DUAL;
        if (f[21] ? f[20] : f[20:19] == 2'h3) fm = `CFD_FMT_F40;
        if (f[21:19] == 3'h0 && f[17:16] == 2'h3) fm = `CFD_FMT_F64;
      end else if (f[21:20] == `CFD_UNIT_SHF) begin
        k = `CFD_KIND_ONE;
        u = `CFD_UNIT_SHF;
      end else if (f[21:20] == `CFD_UNIT_MUL) begin
        k = op[7:5] == 3'h0 ? `CFD_KIND_ACCUM : `CFD_KIND_ONE;
        u = `CFD_UNIT_MUL;
        if (op == 8'h30) fm = `CFD_FMT_F40;
        if (op > 8'h30 && op < 8'h34) fm = `CFD_FMT_F64;
      end else if (f[21:20] == `CFD_UNIT_ALU) begin
        for (int j = 0; j < 53; j++)
          if (alu_ops[j] == op) k = `CFD_KIND_ONE;
        if (op[6:4] == 3'h7) k = `CFD_KIND_ADDSUB;
        fm = op[7] ? `CFD_FMT_F40 : op[7:4] == 4'h1 ? `CFD_FMT_F64 : `CFD_FMT_FIX;
        c = k == `CFD_KIND_ONE && op[7:6] == 2'h0 && op[4:3] == 2'h0
            && (op[2:0] == 3'h5 || op[2:0] == 3'h6);
      end
      if (k == `CFD_KIND_NOP) begin
        op = 8'h00;
        u = `CFD_UNIT_ALU;
        fm = `CFD_FMT_FIX;
      end
      exp_dec = {k, u, fm, op, c, k == `CFD_KIND_SHORT};
    end
  endfunction
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    begin
      checks++;
      if (g !== e) begin
        error_cnt++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task automatic send(input logic sh, input logic [22:0] f, input int gap);
    begin
      dq.push_back(exp_dec(sh, f));
      seq_m.offer(sh, f, gap);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    begin
      bq.push_back({32'h0, r});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) bready <= 1'b0;
      end while (awvalid || wvalid || bready);
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    begin
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) rready <= 1'b0;
      end while (arvalid || rready);
    end
  endtask
  task automatic end_sim;
    begin
      chk(34'h0, 34'(dq.size() + rq.size() + bq.size()));
      if (error_cnt == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // result watcher: oldest note against each result that appears
  always @(posedge aclk) begin
    if (aresetn && dec_valid) begin
      if (dq.size() == 0) chk(34'h0, 34'h1);
      else chk({17'h0, dq.pop_front()}, {17'h0, dec_kind, dec_unit, dec_fmt, dec_op,
        dec_carry, dec_dst_is_src});
    end
    if (rvalid && rready) chk(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk(bq.pop_front(), {32'h0, bresp});
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0000_0000, 4'hF};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`CFD_OFF_CTRL, 34'h0_0000_0001);
    axi_rd(`CFD_OFF_FIELD, 34'h0);
    axi_rd(`CFD_OFF_RESULT, 34'h0);
    for (int i = 0; i < 256; i++) begin
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      send(1'b0, {3'h0, i[7:0], rnd[11:0]}, 0);
      send(1'b0, {3'h1, i[7:0], rnd[23:12]}, 0);
      send(1'b0, {1'b1, i[5:0], rnd[31:16]}, 0);
      send(1'b0, {rnd[22:0]}, rnd[25:24]);
      send(1'b1, {7'h00, rnd[27] ? 4'hC : rnd[31:28], i[3:0], rnd[7:0]}, 0);
    end
    send(1'b0, {3'h3, rnd[19:0]}, 1);
    axi_wr(`CFD_OFF_CTRL, 32'h0, `CFD_RESP_OKAY);
    seq_m.offer(1'b0, 23'h001000, 2);
    axi_rd(`CFD_OFF_CTRL, 34'h0);
    axi_wr(`CFD_OFF_CTRL, 32'h1, `CFD_RESP_OKAY);
    dq.push_back(exp_dec(1'b0, 23'h001000));
    axi_wr(`CFD_OFF_FIELD, 32'h0000_1000, `CFD_RESP_OKAY);
    axi_rd(`CFD_OFF_RESULT, 34'h0_0090_6001);
    axi_wr(`CFD_OFF_RESULT, 32'hFFFF_FFFF, `CFD_RESP_OKAY);
    axi_rd(`CFD_OFF_RESULT, 34'h0_0090_6001);
    dq.push_back(exp_dec(1'b0, 23'h7FFFFF));
    axi_wr(`CFD_OFF_FIELD, 32'hFFFF_FFFF, `CFD_RESP_OKAY);
    axi_rd(`CFD_OFF_FIELD, 34'h0_007F_FFFF);
    dq.push_back(exp_dec(1'b1, 23'h00C500));
    axi_wr(`CFD_OFF_SHORT, 32'hFFFF_C500, `CFD_RESP_OKAY);
    axi_rd(`CFD_OFF_SHORT, 34'h0_0000_C500);
    axi_wr(8'h10, 32'h1234_5678, `CFD_RESP_DECERR);
    axi_rd(8'h10, {`CFD_RESP_DECERR, 32'h0});
    repeat (4) @(posedge aclk);
    end_sim;
  end
endmodule

/* verilog/cfd_decoder.v */
// compute field decoder with axi4-lite register access
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "cfd_defines.vh"

// Overview of operation
// - accept a 23-bit compute field as a self-contained operation specifier.
// - bit 22 low means one-unit; bits 21:20 pick unit; bits 19:12 opcode.
// - bit 22 high: bits 21:16 choose multiplier plus alu parallel format.
// - multiplier accumulator transfers decode as their own operation kind.
// - alu opcode high nibble 0111 fixed dual add/sub, 1111 float dual.
// - short form tag 1100 in bits 15:12; bits 11:8 give opcode.
// - short compute uses first register as destination and source.
// - short fixed ops: add, sub, pass, compare, not, increment, decrement.
// - short opcode 0111 is signed integer multiply into first register.
// - short float ops: add, sub, convert, compare, multiply.
// - short logic ops 1100 and, 1101 or, 1110 xor.
// - alu fixed add, subtract, and carry variants.
// - alu fixed half-sum, signed compare, unsigned compare.
// - alu fixed single-operand pass, negate, carry, increment, decrement, abs.
// - alu fixed and, or, xor, complement.
// - alu fixed min, max, clip.
// - alu float add, subtract, half-sum, compare, abs of sum/difference.
// - alu float pass, negate, round, significand extract, abs.
// - alu float exponent scale, exponent extract, reciprocal and root seeds.
// - fix, float, trunc conversions and their scaled variants.
// - float copysign, min, max, clip.
// - 64-bit float ops on register pairs, including fix to fixed register.
module cfd_decoder (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // sequencer side
  input  wire        seq_valid,
  input  wire        seq_short,
  input  wire [22:0] seq_field,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // decoded operation to the datapath
  output reg         dec_valid,
  output reg  [2:0]  dec_kind,
  output reg  [1:0]  dec_unit,
  output reg  [1:0]  dec_fmt,
  output reg  [7:0]  dec_op,
  output reg  [1:0]  dec_dst,
  output reg         dec_two_src,
  output reg         dec_carry,
  output reg         dec_dst_is_src
);

  reg        aw_held_r;
  reg [7:0]  awaddr_r;
  reg        w_held_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg [22:0] field_r;
  reg [15:0] short_r;
  reg        seq_en_r;
  reg        pend_r;
  reg        pend_short_r;
  reg        seen_r;
  reg [22:0] src_field;
  reg        src_short;
  reg        src_go;
  reg [2:0]  kind_nxt;
  reg [1:0]  unit_nxt;
  reg [1:0]  fmt_nxt;
  reg [7:0]  op_nxt;
  reg [1:0]  dst_nxt;
  reg        two_nxt;
  reg        carry_nxt;
  reg        same_nxt;
  reg [31:0] merged;
  wire       wr_go;
  wire [7:0] op8;
  wire [5:0] dual6;
  wire [3:0] sop;

  // byte-enable merge of a register's old value with new data
  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      i;
    begin
      strb_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign op8   = src_field[`CFD_OP_HI:`CFD_OP_LO];
  assign dual6 = src_field[`CFD_DUAL_HI:`CFD_DUAL_LO];
  assign sop   = src_field[`CFD_SOP_HI:`CFD_SOP_LO];

  // source select: sequencer when enabled and offering a field, else a software-posted field
  always @* begin
    src_go    = 1'b0;
    src_short = 1'b0;
    src_field = field_r;
    if (seq_en_r && seq_valid) begin
      src_go    = 1'b1;
      src_short = seq_short;
      src_field = seq_field;
    end else if (pend_r) begin
      src_go    = 1'b1;
      src_short = pend_short_r;
      src_field = pend_short_r ? {7'h00, short_r} : field_r;
    end
  end

  // decode of the selected field
  always @* begin
    kind_nxt  = `CFD_KIND_NOP;
    unit_nxt  = `CFD_UNIT_ALU;
    fmt_nxt   = `CFD_FMT_FIX;
    op_nxt    = 8'h00;
    dst_nxt   = `CFD_DST_NONE;
    two_nxt   = 1'b0;
    carry_nxt = 1'b0;
    same_nxt  = 1'b0;
    if (src_short) begin
      if (src_field[`CFD_STAG_HI:`CFD_STAG_LO] == `CFD_STAG_VAL) begin
        kind_nxt = `CFD_KIND_SHORT;
        op_nxt   = {4'h0, sop};
        same_nxt = 1'b1;
        two_nxt  = 1'b1;
        dst_nxt  = `CFD_DST_FIX;
        case (sop)
          4'h0, 4'h1, 4'h3: two_nxt = 1'b1;
          4'h2, 4'h4, 4'h5, 4'h6: two_nxt = 1'b0;
          4'h7: unit_nxt = `CFD_UNIT_MUL;
          4'h8, 4'h9, 4'hB: begin
            fmt_nxt = `CFD_FMT_F40;
            dst_nxt = `CFD_DST_FLT;
          end
          4'hA: begin
            fmt_nxt = `CFD_FMT_F40;
            dst_nxt = `CFD_DST_FLT;
            two_nxt = 1'b0;
          end
          4'hF: begin
            fmt_nxt  = `CFD_FMT_F40;
            dst_nxt  = `CFD_DST_FLT;
            unit_nxt = `CFD_UNIT_MUL;
          end
          default: two_nxt = 1'b1;
        endcase
        if (sop == 4'h3 || sop == 4'hB) begin
          dst_nxt = `CFD_DST_NONE;
        end
      end
    end else if (src_field[`CFD_MF_BIT]) begin
      // multiplier and alu in parallel
      op_nxt  = {2'h0, dual6};
      two_nxt = 1'b1;
      dst_nxt = `CFD_DST_FIX;
      if (dual6[5]) begin
        kind_nxt = `CFD_KIND_MULADDSUB;
        if (dual6[4]) begin
          fmt_nxt = `CFD_FMT_F40;
          dst_nxt = `CFD_DST_FLT;
        end
      end else begin
        kind_nxt = `CFD_KIND_DUAL;
        if (dual6[4:3] == 2'h0 && dual6[1:0] == 2'h3) begin
          fmt_nxt = `CFD_FMT_F64;
          dst_nxt = `CFD_DST_DBL;
        end else if (dual6[4:3] == 2'h3) begin
          fmt_nxt = `CFD_FMT_F40;
          dst_nxt = `CFD_DST_FLT;
        end
      end
    end else begin
      unit_nxt = src_field[`CFD_UNIT_HI:`CFD_UNIT_LO];
      op_nxt   = op8;
      kind_nxt = `CFD_KIND_ONE;
      case (src_field[`CFD_UNIT_HI:`CFD_UNIT_LO])
        `CFD_UNIT_ALU: begin
          two_nxt = 1'b1;
          dst_nxt = op8[7] ? `CFD_DST_FLT : `CFD_DST_FIX;
          fmt_nxt = op8[7] ? `CFD_FMT_F40 : `CFD_FMT_FIX;
          if (op8[7:4] == 4'h7 || op8[7:4] == 4'hF) begin
            kind_nxt = `CFD_KIND_ADDSUB;
          end else begin
            case (op8)
              8'h01, 8'h02: ;
              8'h05, 8'h06: carry_nxt = 1'b1;
              8'h09: ;
              8'h0A, 8'h0B: dst_nxt = `CFD_DST_NONE;
              8'h21, 8'h22, 8'h29, 8'h2A, 8'h30: two_nxt = 1'b0;
              8'h25, 8'h26: begin
                two_nxt   = 1'b0;
                carry_nxt = 1'b1;
              end
              8'h40, 8'h41, 8'h42: ;
              8'h43: two_nxt = 1'b0;
              8'h61, 8'h62, 8'h63: ;
              8'h81, 8'h82, 8'h89, 8'h91, 8'h92: ;
              8'h8A: dst_nxt = `CFD_DST_NONE;
              8'hA1, 8'hA2, 8'hA5, 8'hB0: two_nxt = 1'b0;
              8'hAD, 8'hC1: begin
                two_nxt = 1'b0;
                dst_nxt = `CFD_DST_FIX;
              end
              8'hBD: ;
              8'hC4, 8'hC5: two_nxt = 1'b0;
              8'hC9, 8'hCD: begin
                two_nxt = 1'b0;
                dst_nxt = `CFD_DST_FIX;
              end
              8'hCA: two_nxt = 1'b0;
              8'hD9, 8'hDD: dst_nxt = `CFD_DST_FIX;
              8'hDA: ;
              8'hE0, 8'hE1, 8'hE2, 8'hE3: ;
              8'h11, 8'h12: begin
                fmt_nxt = `CFD_FMT_F64;
                dst_nxt = `CFD_DST_DBL;
              end
              8'h13: begin
                fmt_nxt = `CFD_FMT_F64;
                dst_nxt = `CFD_DST_NONE;
              end
              8'h14, 8'h15, 8'h16: begin
                fmt_nxt = `CFD_FMT_F64;
                dst_nxt = `CFD_DST_DBL;
                two_nxt = 1'b0;
              end
              8'h17: begin
                fmt_nxt = `CFD_FMT_F64;
                dst_nxt = `CFD_DST_FIX;
                two_nxt = 1'b0;
              end
              default: begin
                kind_nxt = `CFD_KIND_NOP;
                op_nxt   = 8'h00;
                dst_nxt  = `CFD_DST_NONE;
                two_nxt  = 1'b0;
                fmt_nxt  = `CFD_FMT_FIX;
              end
            endcase
          end
        end
        `CFD_UNIT_MUL: begin
          two_nxt = 1'b1;
          dst_nxt = `CFD_DST_FIX;
          if (op8 == 8'h30) begin
            fmt_nxt = `CFD_FMT_F40;
            dst_nxt = `CFD_DST_FLT;
          end else if (op8 == 8'h31 || op8 == 8'h32 || op8 == 8'h33) begin
            fmt_nxt = `CFD_FMT_F64;
            dst_nxt = `CFD_DST_DBL;
          end else if (op8[7:5] == 3'h0) begin
            kind_nxt = `CFD_KIND_ACCUM;
            two_nxt  = 1'b0;
          end
        end
        `CFD_UNIT_SHF: begin
          two_nxt = 1'b1;
          dst_nxt = `CFD_DST_FIX;
        end
        default: begin
          kind_nxt = `CFD_KIND_NOP;
          unit_nxt = `CFD_UNIT_ALU;
          op_nxt   = 8'h00;
        end
      endcase
    end
  end

  always @* begin
    merged = 32'h00000000;
    case (awaddr_r)
      `CFD_OFF_FIELD: merged = strb_merge({9'h000, field_r}, wdata_r, wstrb_r);
      `CFD_OFF_SHORT: merged = strb_merge({16'h0000, short_r}, wdata_r, wstrb_r);
      `CFD_OFF_CTRL:  merged = strb_merge({31'h0, seq_en_r}, wdata_r, wstrb_r);
      default:        merged = 32'h00000000;
    endcase
  end

  // axi write channels and software registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CFD_RESP_OKAY;
      aw_held_r     <= 1'b0;
      awaddr_r      <= 8'h00;
      w_held_r      <= 1'b0;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      field_r       <= `CFD_RST_FIELD;
      short_r       <= `CFD_RST_SHORT;
      seq_en_r      <= `CFD_RST_CTRL;
      pend_r        <= 1'b0;
      pend_short_r  <= 1'b0;
    end else begin
      if (s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_held_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end else if (s_axi_awvalid && !aw_held_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end else if (s_axi_wvalid && !w_held_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (src_go && !(seq_en_r && seq_valid)) begin
        pend_r <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CFD_RESP_OKAY;
        case (awaddr_r)
          `CFD_OFF_FIELD: begin
            field_r      <= merged[22:0];
            pend_r       <= 1'b1;
            pend_short_r <= 1'b0;
          end
          `CFD_OFF_SHORT: begin
            short_r      <= merged[15:0];
            pend_r       <= 1'b1;
            pend_short_r <= 1'b1;
          end
          `CFD_OFF_CTRL: seq_en_r <= merged[0];
          `CFD_OFF_RESULT: ;
          default: s_axi_bresp <= `CFD_RESP_DECERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CFD_RESP_OKAY;
    end else if (s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `CFD_RESP_OKAY;
      case (s_axi_araddr)
        `CFD_OFF_FIELD:  s_axi_rdata <= {9'h000, field_r};
        `CFD_OFF_SHORT:  s_axi_rdata <= {16'h0000, short_r};
        `CFD_OFF_RESULT: s_axi_rdata <= {8'h00, seen_r, dec_kind, dec_unit, dec_fmt,
                                         dec_dst, dec_two_src, dec_carry,
                                         dec_dst_is_src, 3'h0, dec_op};
        `CFD_OFF_CTRL:   s_axi_rdata <= {31'h0, seq_en_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `CFD_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // registered decode result
  always @(posedge aclk) begin
    if (!aresetn) begin
      dec_valid      <= 1'b0;
      dec_kind       <= `CFD_KIND_NOP;
      dec_unit       <= `CFD_UNIT_ALU;
      dec_fmt        <= `CFD_FMT_FIX;
      dec_op         <= 8'h00;
      dec_dst        <= `CFD_DST_NONE;
      dec_two_src    <= 1'b0;
      dec_carry      <= 1'b0;
      dec_dst_is_src <= 1'b0;
      seen_r         <= 1'b0;
    end else begin
      dec_valid <= src_go;
      if (src_go) begin
        dec_kind       <= kind_nxt;
        dec_unit       <= unit_nxt;
        dec_fmt        <= fmt_nxt;
        dec_op         <= op_nxt;
        dec_dst        <= dst_nxt;
        dec_two_src    <= two_nxt;
        dec_carry      <= carry_nxt;
        dec_dst_is_src <= same_nxt;
        seen_r         <= 1'b1;
      end
    end
  end

endmodule

/* verilog/cfd_defines.vh */
// constants for the compute field decoder: offsets, field positions, codes
`ifndef CFD_DEFINES_VH
`define CFD_DEFINES_VH

// register byte offsets
`define CFD_OFF_FIELD      8'h00
`define CFD_OFF_SHORT      8'h04
`define CFD_OFF_RESULT     8'h08
`define CFD_OFF_CTRL       8'h0C

// reset values
`define CFD_RST_FIELD      23'h000000
`define CFD_RST_SHORT      16'h0000
`define CFD_RST_CTRL       1'h1

// compute field positions
`define CFD_FIELD_W        23
`define CFD_MF_BIT         22
`define CFD_UNIT_HI        21
`define CFD_UNIT_LO        20
`define CFD_OP_HI          19
`define CFD_OP_LO          12
`define CFD_DUAL_HI        21
`define CFD_DUAL_LO        16
`define CFD_SHORT_W        16
`define CFD_STAG_HI        15
`define CFD_STAG_LO        12
`define CFD_SOP_HI         11
`define CFD_SOP_LO         8
`define CFD_STAG_VAL       4'hC

// unit select codes
`define CFD_UNIT_ALU       2'h0
`define CFD_UNIT_MUL       2'h1
`define CFD_UNIT_SHF       2'h2

// operation kinds
`define CFD_KIND_NOP       3'h0
`define CFD_KIND_ONE       3'h1
`define CFD_KIND_DUAL      3'h2
`define CFD_KIND_ADDSUB    3'h3
`define CFD_KIND_ACCUM     3'h4
`define CFD_KIND_SHORT     3'h5
`define CFD_KIND_MULADDSUB 3'h6

// data formats
`define CFD_FMT_FIX        2'h0
`define CFD_FMT_F40        2'h1
`define CFD_FMT_F64        2'h2

// destination kinds
`define CFD_DST_NONE       2'h0
`define CFD_DST_FIX        2'h1
`define CFD_DST_FLT        2'h2
`define CFD_DST_DBL        2'h3

// axi responses
`define CFD_RESP_OKAY      2'h0
`define CFD_RESP_DECERR    2'h3

`endif
